// File: pkg/uemr_pkg.sv
// Functional notes
// [R01] Mode 0000 ignores Setup, In and Out; no handshake.
// [R02] 0001 accept/NAK/NAK; 0011 accept/stall/stall; 0100 accept/ignore/ignore.
// [R03] 0010 stall In, check Out; 0110 zero In, stall Out; check needs empty DATA1.
// [R04] 0101 always accepts Out; 0111 sends counted In; others ignored.
// [R05] 1001 ACKs Out then becomes 1000; 1000 NAKs Out.
// [R06] 1011 accept, zero In, ACK Out then 1010; 1010 NAKs Out.
// [R07] 1101 sends counted In then 1100; 1100 NAKs In.
// [R08] 1111 accept, counted In, check Out then 1110; 1110 NAKs In. Code moves to 1110 after the ACKed In; an ACKed Out check keeps 1111.
// [R09] Setup on enabled accepting endpoint forces mode 0001.
// [R10] Setup-accepting modes answer a valid Setup with ACK.
// [R11] Endpoints reset disabled; engine never leaves disabled mode.
// [R12] Invalid transactions are silently ignored.
// [R13] Interrupt on valid completion or buffer corruption.
// [R14] Data packet valid only if length with CRC at most 10 and error free.
// [R15] Non-control modes ignore Setup.
// [R16] Out-only endpoints ignore In, In-only ignore Out.
// [R17] Endpoint zero In/Out status bits update at transaction end.
// [R18] Setup status bit updates at start of data phase.
// [R19] Endpoint zero mode and count locked after any ACK transaction.
// [R20] Lock clears on CPU read after transaction completes.
// [R21] Each of three endpoints has its own interrupt.
// [R22] Endpoint zero keeps sticky Setup, In, Out received bits.
// [R23] Mode code sits in low four bits of mode register.
// [R24] Count register low four bits hold In byte count, 0..8.
// [R25] Count bit 7 selects data toggle, 0 DATA0, 1 DATA1.
// [R26] Acknowledge bit set when a transaction completes with ACK.
package uemr_pkg;
  localparam int NUM_EP = 3;
  localparam logic [3:0] ADDR_CNT0 = 4'h1;
  localparam logic [3:0] ADDR_MODE0 = 4'h2;
  localparam logic [3:0] ADDR_CNT1 = 4'h3;
  localparam logic [3:0] ADDR_MODE1 = 4'h4;
  localparam logic [3:0] ADDR_CNT2 = 4'h5;
  localparam logic [3:0] ADDR_MODE2 = 4'h6;
  localparam int MODE_ACK_BIT = 4;
  localparam int MODE_OUT_BIT = 5;
  localparam int MODE_IN_BIT = 6;
  localparam int MODE_SETUP_BIT = 7;
  localparam int CNT_TOGGLE_BIT = 7;
  localparam int CNT_VALID_BIT = 6;
  localparam logic [3:0] MAX_IN_BYTES = 4'h8;
  localparam logic [3:0] MAX_RX_BYTES = 4'ha;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [3:0] M_DISABLE = 4'h0;
  localparam logic [3:0] M_NAK_INOUT = 4'h1;
  localparam logic [3:0] M_STATUS_OUT = 4'h2;
  localparam logic [3:0] M_STALL_INOUT = 4'h3;
  localparam logic [3:0] M_IGNORE_INOUT = 4'h4;
  localparam logic [3:0] M_ISO_OUT = 4'h5;
  localparam logic [3:0] M_STATUS_IN = 4'h6;
  localparam logic [3:0] M_ISO_IN = 4'h7;
  localparam logic [3:0] M_NAK_OUT = 4'h8;
  localparam logic [3:0] M_ACK_OUT = 4'h9;
  localparam logic [3:0] M_NAK_OUT_SIN = 4'ha;
  localparam logic [3:0] M_ACK_OUT_SIN = 4'hb;
  localparam logic [3:0] M_NAK_IN = 4'hc;
  localparam logic [3:0] M_ACK_IN = 4'hd;
  localparam logic [3:0] M_NAK_IN_SOUT = 4'he;
  localparam logic [3:0] M_ACK_IN_SOUT = 4'hf;

  typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT} uemr_tok_type;
  typedef enum logic [2:0] {
    RSP_IGNORE, RSP_ACCEPT, RSP_NAK, RSP_STALL, RSP_CHECK, RSP_TX0, RSP_TXCNT
  } uemr_rsp_type;
  typedef enum logic [2:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL, HS_DATA} uemr_hs_type;

  // Token event from the serial bus engine front end
  typedef struct packed {
    logic tokValid;
    uemr_tok_type tok;
    logic [1:0] ep;
  } uemr_tok_evt_type;

  // Data packet phase summary
  typedef struct packed {
    logic dataStart;
    logic dataEnd;
    logic [3:0] len;
    logic crcOk;
    logic toggle;
  } uemr_data_evt_type;

  typedef struct packed {
    logic valid;
    uemr_hs_type hs;
    logic [1:0] ep;
    logic toggle;
    logic [3:0] count;
  } uemr_reply_type;

  typedef struct packed {
    logic [2:0] rsp;
    logic rspErr;
  } uemr_misc_type;
endpackage

// File: hw/uemr_responder.sv
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uemr_responder
  import uemr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire uemr_tok_evt_type tokEvt,
  input wire uemr_data_evt_type dataEvt,
  input wire logic hostAck,
  input wire logic bufCorrupt,
  output uemr_reply_type reply,
  output logic [NUM_EP-1:0] epIrq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_DATA, S_WAIT_ACK} uemr_phase_type;

  typedef struct packed {
    logic [NUM_EP-1:0][7:0] mode;
    logic [NUM_EP-1:0][7:0] cnt;
    uemr_phase_type phase;
    uemr_tok_type tok;
    logic [1:0] ep;
    uemr_rsp_type rsp;
    logic lock0;
    logic setupHold;
    logic [7:0] rdata;
    uemr_reply_type reply;
    logic [NUM_EP-1:0] irq;
  } uemr_state_type;

  uemr_state_type st_r;
  uemr_state_type st_nxt;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // [R01] Truth table
  function automatic uemr_rsp_type decode(input logic [3:0] m, input uemr_tok_type t);
    uemr_rsp_type s;
    uemr_rsp_type i;
    uemr_rsp_type o;
    s = RSP_IGNORE;
    i = RSP_IGNORE;
    o = RSP_IGNORE;
    case (m)
      // [R02] Control modes
      M_NAK_INOUT: begin
        s = RSP_ACCEPT; i = RSP_NAK; o = RSP_NAK;
      end
      // [R03] Status Out mode, then [R02] stall and ignore modes
      M_STATUS_OUT: begin
        s = RSP_ACCEPT; i = RSP_STALL; o = RSP_CHECK;
      end
      M_STALL_INOUT: begin
        s = RSP_ACCEPT; i = RSP_STALL; o = RSP_STALL;
      end
      M_IGNORE_INOUT: begin
        s = RSP_ACCEPT;
      end
      // [R04] Isochronous modes, with [R03] status In mode 0110
      M_ISO_OUT: o = RSP_ACCEPT;
      M_STATUS_IN: begin
        s = RSP_ACCEPT; i = RSP_TX0; o = RSP_STALL;
      end
      M_ISO_IN: i = RSP_TXCNT;
      // [R05] Out-only modes
      M_NAK_OUT: o = RSP_NAK;
      M_ACK_OUT: o = RSP_ACCEPT;
      // [R06] Out with status In
      M_NAK_OUT_SIN: begin
        s = RSP_ACCEPT; i = RSP_TX0; o = RSP_NAK;
      end
      M_ACK_OUT_SIN: begin
        s = RSP_ACCEPT; i = RSP_TX0; o = RSP_ACCEPT;
      end
      // [R07] In-only modes
      M_NAK_IN: i = RSP_NAK;
      M_ACK_IN: i = RSP_TXCNT;
      // [R08] In with status Out
      M_NAK_IN_SOUT: begin
        s = RSP_ACCEPT; i = RSP_NAK; o = RSP_CHECK;
      end
      M_ACK_IN_SOUT: begin
        s = RSP_ACCEPT; i = RSP_TXCNT; o = RSP_CHECK;
      end
      default: begin
        s = RSP_IGNORE;
      end
    endcase
    // [R15] Setup column ignore; [R16] wrong direction ignore
    case (t)
      TOK_SETUP: decode = s;
      TOK_IN: decode = i;
      TOK_OUT: decode = o;
      default: decode = RSP_IGNORE;
    endcase
  endfunction

  // Post-ACK mode: ACK modes (odd, bit 3 set) drop to their NAK twin, but only
  // for an ACK in the direction where the twins differ; the other direction keeps the mode
  function automatic logic [3:0] after_ack(input logic [3:0] m, input uemr_tok_type t);
    logic twinDir;
    twinDir = m[2] ? (t == TOK_IN) : (t == TOK_OUT);
    if (m[3] && m[0] && twinDir) begin
      after_ack = {m[3:1], 1'b0};
    end else begin
      after_ack = m;
    end
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [1:0] wrEp;
  logic rxGood;
  logic checkOk;
  logic done;
  logic acked;
  uemr_rsp_type curRsp;
  logic [1:0] doneEp;
  uemr_tok_type doneTok;

  always_comb begin
    st_nxt = st_r;
    st_nxt.reply.valid = 1'b0;
    st_nxt.irq = '0;
    wrEp = regAddr[2:1] - 2'd1;
    // [R14] Length with CRC and error checks
    rxGood = dataEvt.dataEnd && dataEvt.crcOk && (dataEvt.len <= MAX_RX_BYTES);
    // Zero data bytes means only the two CRC bytes
    checkOk = rxGood && (dataEvt.len == 4'h2) && dataEvt.toggle;
    done = 1'b0;
    acked = 1'b0;
    // [R23] Low nibble mode
    curRsp = decode(st_r.mode[tokEvt.ep][3:0], tokEvt.tok);
    // An In token answered with NAK or STALL completes at once in the idle phase, so the token names the endpoint
    doneEp = (st_r.phase == S_IDLE) ? tokEvt.ep : st_r.ep;
    doneTok = (st_r.phase == S_IDLE) ? tokEvt.tok : st_r.tok;

    // --------------------------------------------------------------
    // Register read
    // --------------------------------------------------------------
    // A read of a locked endpoint zero register in the idle phase unlocks it
    if (regRd) begin
      case (regAddr)
        ADDR_CNT0, ADDR_CNT1, ADDR_CNT2: st_nxt.rdata = st_r.cnt[regAddr[2:1]];
        ADDR_MODE0: st_nxt.rdata = st_r.mode[0];
        ADDR_MODE1, ADDR_MODE2: st_nxt.rdata = {3'b000, st_r.mode[wrEp][4:0]};
        default: st_nxt.rdata = 8'h00;
      endcase
      // [R20] Unlock on read after completion
      if ((regAddr == ADDR_MODE0 || regAddr == ADDR_CNT0) && st_r.phase == S_IDLE) begin
        st_nxt.lock0 = 1'b0;
        st_nxt.setupHold = 1'b0;
      end
    end

    // --------------------------------------------------------------
    // Register write
    // --------------------------------------------------------------
    if (regWr) begin
      case (regAddr)
        ADDR_CNT0, ADDR_CNT1, ADDR_CNT2: begin
          // [R19] Count zero write lock
          if (!(regAddr == ADDR_CNT0 && st_r.lock0)) begin
            st_nxt.cnt[regAddr[2:1]] = regWdata;
          end
        end
        ADDR_MODE0: begin
          if (!st_r.lock0) begin
            st_nxt.mode[0] = regWdata;
            // Setup bit cannot be cleared while held
            if (st_r.setupHold) begin
              st_nxt.mode[0][MODE_SETUP_BIT] = 1'b1;
            end
          end
        end
        ADDR_MODE1, ADDR_MODE2: st_nxt.mode[wrEp] = {3'b000, regWdata[4:0]};
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end

    // --------------------------------------------------------------
    // Transaction sequencing
    // --------------------------------------------------------------
    // Hardware updates below win over same-cycle CPU writes
    case (st_r.phase)
      S_IDLE: begin
        // [R12] Only valid tokens to enabled endpoints
        if (tokEvt.tokValid && tokEvt.ep < 2'(NUM_EP) && curRsp != RSP_IGNORE) begin
          st_nxt.tok = tokEvt.tok;
          st_nxt.ep = tokEvt.ep;
          st_nxt.rsp = curRsp;
          if (tokEvt.tok == TOK_IN) begin
            st_nxt.reply.valid = 1'b1;
            st_nxt.reply.ep = tokEvt.ep;
            st_nxt.reply.toggle = st_r.cnt[tokEvt.ep][CNT_TOGGLE_BIT];
            st_nxt.reply.count = 4'h0;
            case (curRsp)
              RSP_NAK: st_nxt.reply.hs = HS_NAK;
              RSP_STALL: st_nxt.reply.hs = HS_STALL;
              default: begin
                st_nxt.reply.hs = HS_DATA;
                // [R24] Count clamped to legal range
                if (curRsp == RSP_TXCNT) begin
                  st_nxt.reply.count = (st_r.cnt[tokEvt.ep][3:0] > MAX_IN_BYTES) ? MAX_IN_BYTES
                                       : st_r.cnt[tokEvt.ep][3:0];
                end
              end
            endcase
            // [R25] Toggle from count bit 7
            st_nxt.phase = (st_nxt.reply.hs == HS_DATA) ? S_WAIT_ACK : S_IDLE;
            done = (st_nxt.reply.hs != HS_DATA);
          end else begin
            st_nxt.phase = S_DATA;
          end
        end
      end
      S_DATA: begin
        // [R18] Setup status at data start
        if (dataEvt.dataStart && st_r.tok == TOK_SETUP && st_r.ep == 2'd0) begin
          st_nxt.mode[0][MODE_SETUP_BIT] = 1'b1;
          st_nxt.setupHold = 1'b1;
        end
        if (dataEvt.dataEnd) begin
          st_nxt.phase = S_IDLE;
          if (rxGood) begin
            st_nxt.reply.valid = 1'b1;
            st_nxt.reply.ep = st_r.ep;
            st_nxt.reply.toggle = 1'b0;
            st_nxt.reply.count = 4'h0;
            done = 1'b1;
            case (st_r.rsp)
              // [R10] Setup gets ACK
              RSP_ACCEPT: st_nxt.reply.hs = HS_ACK;
              RSP_NAK: st_nxt.reply.hs = HS_NAK;
              RSP_STALL: st_nxt.reply.hs = HS_STALL;
              RSP_CHECK: st_nxt.reply.hs = checkOk ? HS_ACK : HS_STALL;
              default: st_nxt.reply.hs = HS_NONE;
            endcase
            // Isochronous Out carries no handshake
            if (st_r.mode[st_r.ep][3:0] == M_ISO_OUT) begin
              st_nxt.reply.valid = 1'b0;
            end
            // A silent isochronous Out sends no ACK, so it sets no acknowledge bit
            acked = st_nxt.reply.valid && (st_nxt.reply.hs == HS_ACK);
            st_nxt.cnt[st_r.ep][3:0] = dataEvt.len;
            st_nxt.cnt[st_r.ep][CNT_VALID_BIT] = 1'b1;
            st_nxt.cnt[st_r.ep][CNT_TOGGLE_BIT] = dataEvt.toggle;
            // [R09] Setup forces NAK-both
            if (st_r.tok == TOK_SETUP && st_r.mode[st_r.ep][3:0] != M_DISABLE) begin
              st_nxt.mode[st_r.ep][3:0] = M_NAK_INOUT;
              st_nxt.setupHold = 1'b0;
            end
          end else begin
            // [R12] Bad data: stay silent
            st_nxt.setupHold = 1'b0;
          end
        end
      end
      S_WAIT_ACK: begin
        if (hostAck) begin
          acked = 1'b1;
          done = 1'b1;
          st_nxt.phase = S_IDLE;
        end else if (tokEvt.tokValid) begin
          // Host moved on without an ACK: drop the transaction
          st_nxt.phase = S_IDLE;
        end
      end
      default: st_nxt.phase = S_IDLE;
    endcase

    // --------------------------------------------------------------
    // Status bits and interrupts
    // --------------------------------------------------------------
    if (done) begin
      // [R17] In/Out status at end
      // [R22] Sticky token bits
      if (doneEp == 2'd0) begin
        if (doneTok == TOK_IN) begin
          st_nxt.mode[0][MODE_IN_BIT] = 1'b1;
        end
        if (doneTok == TOK_OUT) begin
          st_nxt.mode[0][MODE_OUT_BIT] = 1'b1;
        end
      end
      // [R13] Completion interrupt; [R21] one per endpoint
      st_nxt.irq[doneEp] = 1'b1;
    end
    if (acked) begin
      // [R26] Acknowledge bit
      st_nxt.mode[st_r.ep][MODE_ACK_BIT] = 1'b1;
      // [R05] ACK modes fall to NAK twin
      if (st_r.tok != TOK_SETUP) begin
        st_nxt.mode[st_r.ep][3:0] = after_ack(st_r.mode[st_r.ep][3:0], st_r.tok);
      end
      // [R19] Lock endpoint zero registers
      if (st_r.ep == 2'd0) begin
        st_nxt.lock0 = 1'b1;
      end
    end
    // [R13] Buffer corruption interrupt
    if (bufCorrupt) begin
      st_nxt.irq[st_r.ep] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // [R11] Endpoints reset disabled
      for (int e = 0; e < NUM_EP; e++) begin
        st_r.mode[e] <= MODE_RESET;
        st_r.cnt[e] <= CNT_RESET;
      end
      st_r.phase <= S_IDLE;
      st_r.tok <= TOK_SETUP;
      st_r.ep <= 2'd0;
      st_r.rsp <= RSP_IGNORE;
      st_r.lock0 <= 1'b0;
      st_r.setupHold <= 1'b0;
      st_r.rdata <= 8'h00;
      st_r.reply <= '0;
      st_r.irq <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdata = st_r.rdata;
  assign reply = st_r.reply;
  assign epIrq = st_r.irq;
endmodule
`default_nettype wire

// File: verif/uemr_responder_properties.sv
`timescale 1ns/1ps
`default_nettype none
module uemr_responder_checker
  import uemr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire uemr_tok_evt_type tokEvt,
  input wire uemr_data_evt_type dataEvt,
  input wire logic bufCorrupt,
  input wire uemr_reply_type reply,
  input wire logic [NUM_EP-1:0] epIrq
);
  // ----------------------------------------
  // Link and register relations
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  property p_rsp_cause;
    reply.valid |-> $past(tokEvt.tokValid && tokEvt.tok == TOK_IN) || $past(dataEvt.dataEnd);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("reply without a cause");
  property p_rsp_pulse;
    reply.valid |=> !reply.valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("reply valid too long");
  property p_bad_data;
    dataEvt.dataEnd && (!dataEvt.crcOk || dataEvt.len > MAX_RX_BYTES) |=> !reply.valid;
  endproperty
  a_bad_data: assert property (p_bad_data) else $error("reply to bad data");
  property p_bad_ep;
    tokEvt.tokValid && tokEvt.ep == 2'h3 |=> !reply.valid [*4];
  endproperty
  a_bad_ep: assert property (p_bad_ep) else $error("reply to missing endpoint");
  property p_irq_one;
    $onehot0(epIrq);
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("two endpoint interrupts");
  property p_buf_irq;
    bufCorrupt |-> ##[1:4] (epIrq != '0);
  endproperty
  a_buf_irq: assert property (p_buf_irq) else $error("no interrupt on corruption");
  property p_in_cnt;
    reply.valid && reply.hs == HS_DATA |-> reply.count <= MAX_IN_BYTES;
  endproperty
  a_in_cnt: assert property (p_in_cnt) else $error("In count above eight");
  property p_rsv_bits;
    regRd && (regAddr == ADDR_MODE1 || regAddr == ADDR_MODE2) |=> regRdata[7:5] == 3'h0;
  endproperty
  a_rsv_bits: assert property (p_rsv_bits) else $error("reserved mode bits set");
endmodule
`default_nettype wire

// File: verif/uemr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module uemr_host_model
  import uemr_pkg::*;
(
  input wire logic sys_clk,
  input wire uemr_reply_type reply,
  input wire logic [NUM_EP-1:0] epIrq,
  output uemr_tok_evt_type tokEvt,
  output uemr_data_evt_type dataEvt,
  output logic hostAck,
  output logic bufCorrupt
);
  uemr_reply_type got;
  logic [NUM_EP-1:0] irqSeen;
  initial begin
    tokEvt = '0;
    dataEvt = '0;
    hostAck = 1'b0;
    bufCorrupt = 1'b0;
  end
  // Replies and interrupts are pulses, so latch them mid-cycle
  always @(negedge sys_clk) begin
    if (reply.valid === 1'b1) got = reply;
    irqSeen = irqSeen | epIrq;
  end
  task automatic xfer(input uemr_tok_type tk, input logic [1:0] ep, input logic [3:0] len, input logic crc,
                      input logic tog, input logic crpt);
    got = '0;
    irqSeen = '0;
    @(posedge sys_clk);
    tokEvt <= '{1'b1, tk, ep};
    @(posedge sys_clk);
    tokEvt <= '{1'b0, tk, ~ep};
    if (tk != TOK_IN) begin
      @(posedge sys_clk);
      dataEvt <= '{1'b1, 1'b0, len, crc, tog};
      bufCorrupt <= crpt;
      @(posedge sys_clk);
      dataEvt <= '{1'b0, 1'b1, len, crc, tog};
      bufCorrupt <= 1'b0;
      @(posedge sys_clk);
      dataEvt <= '{1'b0, 1'b0, ~len, ~crc, ~tog};
    end
    repeat (2) @(posedge sys_clk);
    if (got.hs == HS_DATA) begin
      hostAck <= 1'b1;
      @(posedge sys_clk);
      hostAck <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// File: verif/uemr_responder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uemr_responder_tb;
  import uemr_pkg::*;
  logic sys_clk;
  logic sys_rst;
  logic [3:0] regAddr;
  logic [7:0] regWdata;
  logic regWr;
  logic regRd;
  logic [7:0] regRdata;
  uemr_tok_evt_type tokEvt;
  uemr_data_evt_type dataEvt;
  logic hostAck;
  logic bufCorrupt;
  uemr_reply_type reply;
  logic [NUM_EP-1:0] epIrq;
  int n_fail;
  int num_checks;
  // Letter per mode code: Ignore Accept Nak Stall Check Zero-In Txcnt acK W=silent
  string setupRsp = "IAAAAIAIIIAAIIAA";
  string inRsp = "INSSIIZTIIZZNTNT";
  string outRsp = "INCSIWSINKNKIICC";
  uemr_responder DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .tokEvt(tokEvt), .dataEvt(dataEvt),
    .hostAck(hostAck), .bufCorrupt(bufCorrupt), .reply(reply), .epIrq(epIrq));
  uemr_host_model HOST (.sys_clk(sys_clk), .reply(reply), .epIrq(epIrq), .tokEvt(tokEvt),
    .dataEvt(dataEvt), .hostAck(hostAck), .bufCorrupt(bufCorrupt));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] expv, input logic [7:0] got);
    num_checks++;
    if (got !== expv) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, expv, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    d = regRdata;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #5000000;
    n_fail++;
    $display("watchdog expired");
    final_report;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [1:0] ep;
    logic [7:0] cnt;
    logic [7:0] v;
    logic [7:0] mask;
    logic [3:0] len;
    logic [2:0] hs;
    logic bad;
    logic k;
    byte c;
    sys_rst = 1'b1;
    regAddr = '0;
    regWdata = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    n_fail = 0;
    num_checks = 0;
    void'($urandom(32'hcad8));
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(4'(a), v);
      chk("reset reg", 8'h00, v);
    end
    $display("test reset done");
    for (int m = 0; m < 16; m++) begin
      for (int t = 0; t < 3; t++) begin
        ep = 2'($urandom_range(2, 1));
        cnt = {1'($urandom_range(1, 0)), 3'h0, 4'($urandom_range(8, 0))};
        c = (t == 0) ? setupRsp[m] : (t == 1) ? inRsp[m] : outRsp[m];
        bad = ($urandom_range(3, 0) == 0) && t != 1;
        k = 1'($urandom_range(1, 0));
        len = (bad && k) ? 4'($urandom_range(15, 11)) : (c == "C") ? 4'h2 : 4'($urandom_range(10, 2));
        wr(4'(2 * ep + 1), cnt);
        wr(4'(2 * ep + 2), 8'(m));
        HOST.xfer(uemr_tok_type'(t), ep, len, !(bad && !k), (c == "C") | k, bad && c != "I");
        hs = (c == "A" || c == "K" || c == "C") ? HS_ACK : (c == "N") ? HS_NAK : (c == "S") ? HS_STALL :
             (c == "Z" || c == "T") ? HS_DATA : HS_NONE;
        if (bad) hs = HS_NONE;
        chk("reply", {5'(|hs), hs}, {5'(HOST.got.valid), HOST.got.hs});
        if (hs != HS_NONE) chk("reply ep", 8'(ep), 8'(HOST.got.ep));
        if (c == "T") chk("In count", cnt, {HOST.got.toggle, 3'h0, HOST.got.count});
        if (c == "Z") chk("empty In", 8'h00, 8'(HOST.got.count));
        if ((hs == HS_ACK || hs == HS_DATA) && m != 7) chk("irq", 8'(1 << ep), 8'(HOST.irqSeen));
        if (bad && c != "I") chk("corrupt irq", 8'h01, 8'(HOST.irqSeen[ep]));
        mask = (m == 7) ? 8'h0f : 8'hff;
        v = {3'h0, c == "K" || c == "Z" || c == "T" || c == "C", 4'(m)};
        if (c == "K" || (c == "T" && m != 7)) v[0] = 1'b0;
        if (t == 0 && c == "A") v = 8'h11;
        rd(4'(2 * ep + 2), cnt);
        if (!bad) chk("mode after", v & mask, cnt & mask);
      end
    end
    $display("test mode table done");
    wr(ADDR_CNT0, 8'h83);
    wr(ADDR_MODE0, {4'h0, M_ACK_IN});
    HOST.xfer(TOK_IN, 2'h0, 4'h0, 1'b1, 1'b0, 1'b0);
    chk("ep0 In", 8'h83, {HOST.got.toggle, 3'h0, HOST.got.count});
    wr(ADDR_MODE0, 8'h01);
    wr(ADDR_CNT0, 8'h05);
    rd(ADDR_MODE0, v);
    chk("locked mode0", 8'h5c, v);
    rd(ADDR_CNT0, v);
    chk("locked cnt0", 8'h83, v);
    wr(ADDR_MODE0, 8'h03);
    rd(ADDR_MODE0, v);
    chk("unlocked mode0", 8'h03, v);
    HOST.xfer(TOK_SETUP, 2'h0, 4'ha, 1'b1, 1'b0, 1'b0);
    wr(ADDR_MODE0, 8'h04);
    rd(ADDR_MODE0, v);
    chk("setup mode0", 8'h91, v);
    HOST.xfer(TOK_IN, 2'h3, 4'h0, 1'b1, 1'b0, 1'b0);
    chk("missing ep", 8'h00, 8'(HOST.got.valid));
    $display("test endpoint zero done");
    final_report;
  end
endmodule
bind uemr_responder uemr_responder_checker CHK (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
  .regRd(regRd), .regRdata(regRdata), .tokEvt(tokEvt), .dataEvt(dataEvt), .bufCorrupt(bufCorrupt),
  .reply(reply), .epIrq(epIrq));
`default_nettype wire
